// ---- common/ifd_params.svh ----
/*
 * Constants of the input fault diagnostic configuration block: register
 * indices, field positions, reset values, threshold steps and event bits.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef IFD_PARAMS_SVH
`define IFD_PARAMS_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define IFD_IDX_CHAN_EN     8'h64
`define IFD_IDX_THR_PB      8'h65
`define IFD_IDX_THR_GB      8'h66
`define IFD_IDX_ADV         8'h67
`define IFD_IDX_STAT        8'h68
`define IFD_IDX_MASK        8'h69
`define IFD_IDX_LIVE        8'h6a

// ==========================================================================
// reset values
`define IFD_RST_CHAN_EN     8'h00
`define IFD_RST_THR_PB      8'h37
`define IFD_RST_THR_GB      8'h87

// ==========================================================================
// field positions
`define IFD_CH_EN_MSB       7
`define IFD_SE_NEG_BIT      1
`define IFD_AC_BIT          0
`define IFD_SCALE_BIT       0
`define IFD_HI_MSB          7
`define IFD_HI_LSB          4
`define IFD_LO_MSB          3
`define IFD_LO_LSB          0
`define IFD_MAX_CHAN        6

// ==========================================================================
// threshold step per code, in mV
`define IFD_STEP_PAIR_MV    8'h1e
`define IFD_STEP_BAT_MV     8'h1e
`define IFD_STEP_GND_MV     8'h3c
`define IFD_STEP_BIAS_MV    8'h1e

// ==========================================================================
// event bits of status and mask
`define IFD_EV_PAIR         0
`define IFD_EV_BAT          1
`define IFD_EV_GND          2
`define IFD_EV_BIAS         3
`define IFD_EV_DONE         4
`define IFD_NUM_EV          5

// ==========================================================================
// bus encodings
`define IFD_HTRANS_NONSEQ   2'h2
`define IFD_HSIZE_WORD      3'h2

`endif

// ---- common/ifd_pkg.sv ----
/*
 * Types shared by the input fault diagnostic configuration block.
 * Assumes nothing of its surroundings.
 */
package ifd_pkg;

    // ======================================================================
    // scan sequencer states
    typedef enum logic [1:0] {
        IFD_ST_IDLE = 2'b00,
        IFD_ST_SEL  = 2'b01,
        IFD_ST_WAIT = 2'b10
    } ifd_state_t;

    typedef logic [3:0] ifd_code_t;

endpackage

// ---- common/ifd_thr_if.sv ----
/*
 * Carries the latched diagnostic thresholds, in mV, from the scan
 * sequencer to the fault comparator.
 * Assumes the source holds the values stable for a whole scan.
 */
`timescale 1ns/100ps

interface ifd_thr_if #(
    parameter int MV_W = 12
);
    logic [MV_W-1:0] pair_mv;
    logic [MV_W-1:0] bat_mv;
    logic [MV_W-1:0] gnd_mv;
    logic [MV_W-1:0] bias_mv;

    modport src (output pair_mv, output bat_mv, output gnd_mv, output bias_mv);
    modport dst (input pair_mv, input bat_mv, input gnd_mv, input bias_mv);
endinterface

// ---- hw/ifd_diag_top.sv ----
/*
 * Input fault diagnostic configuration: AHB-Lite register bank, scan
 * sequencer over the channels, threshold latching, sticky fault events
 * with mask and interrupt.
 * Assumes an analog front end that measures one channel on meas_req and
 * returns pin, battery and bias voltages in mV with meas_valid.
 */
// Summary of operation
// - bits 7..2 enable scanning of channels 1..6
// - channels 5,6 scan only on six-channel variant
// - bit 1 includes single-ended negative pins
// - bit 0 includes AC-coupled channel pins
// - pair threshold bits 7:4, reset 3, 30 mV
// - battery threshold bits 3:0, reset 7, 30 mV
// - ground threshold bits 7:4, reset 8, 60 mV
// - bias threshold bits 3:0, reset 7, 30 mV
// - scaling bit doubles every threshold
// - pair short when pin difference below threshold
// - battery short when pin near battery voltage
`timescale 1ns/100ps
`include "ifd_params.svh"

module ifd_diag_top #(
    parameter int NUM_CHAN = 6,
    parameter int VW       = 15,
    parameter int MV_W     = 12
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic [5:0]    chan_single_ended,
    input  wire logic [5:0]    chan_ac_coupled,
    output logic               meas_req,
    output logic [2:0]         meas_chan,
    output logic               meas_neg_on,
    input  wire logic          meas_valid,
    input  wire logic [VW-1:0] pos_mv,
    input  wire logic [VW-1:0] neg_mv,
    input  wire logic [VW-1:0] vbat_mv,
    input  wire logic [VW-1:0] bias_mv,
    output logic               scan_active,
    output logic               irq
);

    // ======================================================================
    // bus decode
    logic       wr_pend_reg;
    logic [7:0] wr_idx_reg;
    wire        addr_ok  = hsel && hready && htrans == `IFD_HTRANS_NONSEQ &&
                           hsize == `IFD_HSIZE_WORD && haddr[31:10] == 22'h0;
    wire [7:0]  addr_idx = haddr[9:2];
    wire        rd_take  = addr_ok && !hwrite;
    wire        wr_take  = addr_ok && hwrite;
    wire [7:0]  wdat     = hwdata[7:0];

    function automatic logic wr_hit(input logic pend, input logic [7:0] idx,
                                    input logic [7:0] target);
        return pend && idx == target;
    endfunction

    wire w_en   = wr_hit(wr_pend_reg, wr_idx_reg, `IFD_IDX_CHAN_EN);
    wire w_pb   = wr_hit(wr_pend_reg, wr_idx_reg, `IFD_IDX_THR_PB);
    wire w_gb   = wr_hit(wr_pend_reg, wr_idx_reg, `IFD_IDX_THR_GB);
    wire w_adv  = wr_hit(wr_pend_reg, wr_idx_reg, `IFD_IDX_ADV);
    wire w_stat = wr_hit(wr_pend_reg, wr_idx_reg, `IFD_IDX_STAT);
    wire w_mask = wr_hit(wr_pend_reg, wr_idx_reg, `IFD_IDX_MASK);

    // ======================================================================
    // configuration registers
    logic [7:0] chan_en_reg;
    logic [7:0] thr_pb_reg;
    logic [7:0] thr_gb_reg;
    logic       scale_reg;
    logic [`IFD_NUM_EV-1:0] stat_reg;
    logic [`IFD_NUM_EV-1:0] mask_reg;
    logic [5:0] live_reg;

    wire [7:0] chan_en_next = w_en ? wdat : chan_en_reg;
    wire [7:0] thr_pb_next  = w_pb ? wdat : thr_pb_reg;
    wire [7:0] thr_gb_next  = w_gb ? wdat : thr_gb_reg;
    wire       scale_next   = w_adv ? wdat[`IFD_SCALE_BIT] : scale_reg;
    wire [`IFD_NUM_EV-1:0] mask_next = w_mask ? wdat[`IFD_NUM_EV-1:0] : mask_reg;

    wire incl_se = chan_en_reg[`IFD_SE_NEG_BIT];
    wire incl_ac = chan_en_reg[`IFD_AC_BIT];

    // ======================================================================
    // channel eligibility; channel 1 sits in the top enable bit
    logic [5:0] eff_en;
    logic [5:0] pos_on;
    logic [5:0] neg_on;
    for (genvar gi = 0; gi < `IFD_MAX_CHAN; gi++) begin : g_chan
        assign eff_en[gi] = chan_en_reg[`IFD_CH_EN_MSB-gi] && (gi < NUM_CHAN);
        assign pos_on[gi] = eff_en[gi] && (!chan_ac_coupled[gi] || incl_ac);
        assign neg_on[gi] = pos_on[gi] && (!chan_single_ended[gi] || incl_se);
    end

    // ======================================================================
    // thresholds: converted live, latched once per scan
    wire [MV_W-1:0] cv_pair, cv_bat, cv_gnd, cv_bias;

    ifd_thresh_conv #(.MV_W(MV_W)) u_conv (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .code_pair (thr_pb_reg[`IFD_HI_MSB:`IFD_HI_LSB]),
        .code_bat  (thr_pb_reg[`IFD_LO_MSB:`IFD_LO_LSB]),
        .code_gnd  (thr_gb_reg[`IFD_HI_MSB:`IFD_HI_LSB]),
        .code_bias (thr_gb_reg[`IFD_LO_MSB:`IFD_LO_LSB]),
        .scale     (scale_reg),
        .pair_mv   (cv_pair),
        .bat_mv    (cv_bat),
        .gnd_mv    (cv_gnd),
        .bias_mv   (cv_bias)
    );

    ifd_thr_if #(.MV_W(MV_W)) thr ();
    logic [MV_W-1:0] pair_lat_reg;
    logic [MV_W-1:0] bat_lat_reg;
    logic [MV_W-1:0] gnd_lat_reg;
    logic [MV_W-1:0] bias_lat_reg;
    assign thr.pair_mv = pair_lat_reg;
    assign thr.bat_mv  = bat_lat_reg;
    assign thr.gnd_mv  = gnd_lat_reg;
    assign thr.bias_mv = bias_lat_reg;

    wire            f_pair, f_bat, f_gnd, f_bias;

    ifd_fault_cmp #(.VW(VW)) u_cmp (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .thr        (thr.dst),
        .pos_mv     (pos_mv),
        .neg_mv     (neg_mv),
        .vbat_mv    (vbat_mv),
        .bias_mv    (bias_mv),
        .neg_on     (meas_neg_on),
        .pair_short (f_pair),
        .bat_short  (f_bat),
        .gnd_short  (f_gnd),
        .bias_short (f_bias)
    );

    // ======================================================================
    // scan sequencer
    ifd_pkg::ifd_state_t state_reg;
    ifd_pkg::ifd_state_t state_next;
    logic [2:0] chan_reg;

    wire start   = state_reg == ifd_pkg::IFD_ST_IDLE && |eff_en;
    wire cur_pos = pos_on[chan_reg];
    wire cur_neg = neg_on[chan_reg];
    wire issue   = state_reg == ifd_pkg::IFD_ST_SEL && cur_pos;
    wire got     = state_reg == ifd_pkg::IFD_ST_WAIT && meas_valid;
    wire advance = (state_reg == ifd_pkg::IFD_ST_SEL && !cur_pos) || got;
    wire last    = chan_reg == 3'(NUM_CHAN - 1);
    wire any_f   = f_pair || f_bat || f_gnd || f_bias;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ifd_pkg::IFD_ST_IDLE: begin
                if (start) begin
                    state_next = ifd_pkg::IFD_ST_SEL;
                end
            end
            ifd_pkg::IFD_ST_SEL: begin
                if (issue) begin
                    state_next = ifd_pkg::IFD_ST_WAIT;
                end else if (last) begin
                    state_next = ifd_pkg::IFD_ST_IDLE;
                end
            end
            ifd_pkg::IFD_ST_WAIT: begin
                if (got) begin
                    state_next = last ? ifd_pkg::IFD_ST_IDLE : ifd_pkg::IFD_ST_SEL;
                end
            end
            default: state_next = ifd_pkg::IFD_ST_IDLE;
        endcase
    end

    // ======================================================================
    // events, status, interrupt; a new event beats a same-cycle clear
    logic [`IFD_NUM_EV-1:0] ev;
    assign ev[`IFD_EV_PAIR] = got && f_pair;
    assign ev[`IFD_EV_BAT]  = got && f_bat;
    assign ev[`IFD_EV_GND]  = got && f_gnd;
    assign ev[`IFD_EV_BIAS] = got && f_bias;
    assign ev[`IFD_EV_DONE] = advance && last;

    wire [`IFD_NUM_EV-1:0] w1c       = w_stat ? wdat[`IFD_NUM_EV-1:0] : '0;
    wire [`IFD_NUM_EV-1:0] stat_next = (stat_reg & ~w1c) | ev;
    wire [5:0] live_bit = 6'h20 >> chan_reg;
    wire [5:0] live_next = got ? (any_f ? live_reg | live_bit : live_reg & ~live_bit)
                               : live_reg;

    // reads see this cycle's write, so back-to-back write/read is coherent
    wire [7:0] rd_byte =
        (addr_idx == `IFD_IDX_CHAN_EN) ? chan_en_next :
        (addr_idx == `IFD_IDX_THR_PB)  ? thr_pb_next  :
        (addr_idx == `IFD_IDX_THR_GB)  ? thr_gb_next  :
        (addr_idx == `IFD_IDX_ADV)     ? {7'h00, scale_next} :
        (addr_idx == `IFD_IDX_STAT)    ? {3'h0, stat_next} :
        (addr_idx == `IFD_IDX_MASK)    ? {3'h0, mask_next} :
        (addr_idx == `IFD_IDX_LIVE)    ? {live_next, 2'h0} : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 8'h00;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            chan_en_reg <= `IFD_RST_CHAN_EN;
            thr_pb_reg  <= `IFD_RST_THR_PB;
            thr_gb_reg  <= `IFD_RST_THR_GB;
            scale_reg   <= 1'b0;
            stat_reg    <= '0;
            mask_reg    <= '0;
            live_reg    <= 6'h00;
            irq         <= 1'b0;
        end else begin
            wr_pend_reg <= wr_take;
            wr_idx_reg  <= addr_idx;
            hrdata      <= rd_take ? {24'h000000, rd_byte} : 32'h0000_0000;
            chan_en_reg <= chan_en_next;
            thr_pb_reg  <= thr_pb_next;
            thr_gb_reg  <= thr_gb_next;
            scale_reg   <= scale_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            live_reg    <= live_next;
            irq         <= |(stat_next & mask_next);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= ifd_pkg::IFD_ST_IDLE;
            chan_reg     <= 3'h0;
            meas_req     <= 1'b0;
            meas_chan    <= 3'h0;
            meas_neg_on  <= 1'b0;
            scan_active  <= 1'b0;
            pair_lat_reg <= '0;
            bat_lat_reg  <= '0;
            gnd_lat_reg  <= '0;
            bias_lat_reg <= '0;
        end else begin
            state_reg   <= state_next;
            meas_req    <= issue;
            scan_active <= state_next != ifd_pkg::IFD_ST_IDLE;
            if (start) begin
                chan_reg     <= 3'h0;
                pair_lat_reg <= cv_pair;
                bat_lat_reg  <= cv_bat;
                gnd_lat_reg  <= cv_gnd;
                bias_lat_reg <= cv_bias;
            end else if (advance && !last) begin
                chan_reg <= chan_reg + 3'h1;
            end
            if (issue) begin
                meas_chan   <= chan_reg;
                meas_neg_on <= cur_neg;
            end
        end
    end

    // ======================================================================
    // checks
    sequence s_issue;
        state_reg == ifd_pkg::IFD_ST_SEL && cur_pos;
    endsequence
    sequence s_start;
        state_reg == ifd_pkg::IFD_ST_IDLE && |eff_en;
    endsequence

    property p_req_enabled;
        @(posedge hclk) disable iff (!hresetn)
        s_issue |=> meas_req && (chan_en_reg[`IFD_CH_EN_MSB - meas_chan] || $past(w_en));
    endproperty
    a_req_enabled: assert property (p_req_enabled) else $error("disabled channel scanned");
    property p_variant;
        @(posedge hclk) disable iff (!hresetn)
        meas_req |-> meas_chan < 3'(NUM_CHAN);
    endproperty
    a_variant: assert property (p_variant) else $error("channel beyond variant");
    property p_se_neg;
        @(posedge hclk) disable iff (!hresetn)
        (s_issue and (chan_single_ended[chan_reg] && !incl_se)) |=> !meas_neg_on;
    endproperty
    a_se_neg: assert property (p_se_neg) else $error("single-ended negative scanned");
    property p_ac_skip;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == ifd_pkg::IFD_ST_SEL && chan_ac_coupled[chan_reg] && !incl_ac)
            |=> !meas_req;
    endproperty
    a_ac_skip: assert property (p_ac_skip) else $error("ac-coupled channel scanned");
    property p_latch;
        @(posedge hclk) disable iff (!hresetn)
        s_start |=> pair_lat_reg == $past(cv_pair) && gnd_lat_reg == $past(cv_gnd);
    endproperty
    a_latch: assert property (p_latch) else $error("thresholds not latched");
    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg != ifd_pkg::IFD_ST_IDLE) ##1 (state_reg != ifd_pkg::IFD_ST_IDLE)
            |-> $stable(bat_lat_reg) && $stable(bias_lat_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("thresholds moved in scan");
    property p_sticky;
        @(posedge hclk) disable iff (!hresetn)
        ev[`IFD_EV_PAIR] |=> stat_reg[`IFD_EV_PAIR] ##1
            (stat_reg[`IFD_EV_PAIR] || $past(w_stat));
    endproperty
    a_sticky: assert property (p_sticky) else $error("pair event lost");
    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        irq == |(stat_reg & mask_reg);
    endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with status");
endmodule

// ---- hw/ifd_fault_cmp.sv ----
/*
 * Compares one channel's measured pin voltages against the latched
 * thresholds and reports the four short conditions.
 * Assumes the positive pin is always part of a measurement and that
 * voltages are unsigned mV.
 */
`timescale 1ns/100ps
`include "ifd_params.svh"

module ifd_fault_cmp #(
    parameter int VW = 15
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    ifd_thr_if.dst             thr,
    input  wire logic [VW-1:0] pos_mv,
    input  wire logic [VW-1:0] neg_mv,
    input  wire logic [VW-1:0] vbat_mv,
    input  wire logic [VW-1:0] bias_mv,
    input  wire logic          neg_on,
    output logic               pair_short,
    output logic               bat_short,
    output logic               gnd_short,
    output logic               bias_short
);

    function automatic logic [VW-1:0] absdiff(input logic [VW-1:0] a,
                                              input logic [VW-1:0] b);
        return (a > b) ? a - b : b - a;
    endfunction

    wire [VW-1:0] t_pair = VW'(thr.pair_mv);
    wire [VW-1:0] t_bat  = VW'(thr.bat_mv);
    wire [VW-1:0] t_gnd  = VW'(thr.gnd_mv);
    wire [VW-1:0] t_bias = VW'(thr.bias_mv);

    // pair needs both pins; an excluded negative pin yields no fault
    assign pair_short = neg_on && absdiff(pos_mv, neg_mv) < t_pair;
    assign bat_short  = absdiff(vbat_mv, pos_mv) < t_bat ||
                        (neg_on && absdiff(vbat_mv, neg_mv) < t_bat);
    assign gnd_short  = pos_mv < t_gnd || (neg_on && neg_mv < t_gnd);
    assign bias_short = absdiff(bias_mv, pos_mv) < t_bias ||
                        (neg_on && absdiff(bias_mv, neg_mv) < t_bias);

    // ======================================================================
    // checks
    property p_pair_equal;
        @(posedge hclk) disable iff (!hresetn)
        (neg_on && pos_mv == neg_mv && t_pair != '0) |-> pair_short;
    endproperty
    a_pair_equal: assert property (p_pair_equal) else $error("equal pins not short");

    property p_pair_wide;
        @(posedge hclk) disable iff (!hresetn)
        (pos_mv >= neg_mv && pos_mv - neg_mv >= t_pair) |-> !pair_short;
    endproperty
    a_pair_wide: assert property (p_pair_wide) else $error("wide pair flagged");

    property p_bat_far;
        @(posedge hclk) disable iff (!hresetn)
        (!neg_on && vbat_mv >= pos_mv && vbat_mv - pos_mv >= t_bat) |-> !bat_short;
    endproperty
    a_bat_far: assert property (p_bat_far) else $error("far battery flagged");
endmodule

// ---- hw/ifd_thresh_conv.sv ----
/*
 * Turns the four 4-bit threshold codes into mV, doubling all of them
 * when scaling is set.
 * Assumes the codes come straight from the configuration registers.
 */
`timescale 1ns/100ps
`include "ifd_params.svh"

module ifd_thresh_conv #(
    parameter int MV_W = 12
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire ifd_pkg::ifd_code_t code_pair,
    input  wire ifd_pkg::ifd_code_t code_bat,
    input  wire ifd_pkg::ifd_code_t code_gnd,
    input  wire ifd_pkg::ifd_code_t code_bias,
    input  wire logic              scale,
    output logic [MV_W-1:0]        pair_mv,
    output logic [MV_W-1:0]        bat_mv,
    output logic [MV_W-1:0]        gnd_mv,
    output logic [MV_W-1:0]        bias_mv
);

    // ======================================================================
    // linear code times step, every code alike
    function automatic logic [MV_W-1:0] to_mv(input logic [3:0] code,
                                              input logic [7:0] step,
                                              input logic       dbl);
        logic [MV_W-1:0] base;
        base = MV_W'(code) * MV_W'(step);
        return dbl ? MV_W'(base << 1) : base;
    endfunction

    assign pair_mv = to_mv(code_pair, `IFD_STEP_PAIR_MV, scale);
    assign bat_mv  = to_mv(code_bat,  `IFD_STEP_BAT_MV,  scale);
    assign gnd_mv  = to_mv(code_gnd,  `IFD_STEP_GND_MV,  scale);
    assign bias_mv = to_mv(code_bias, `IFD_STEP_BIAS_MV, scale);

    // ======================================================================
    // checks
    property p_pair_top;
        @(posedge hclk) disable iff (!hresetn)
        (code_pair == 4'hf && !scale) |-> pair_mv == MV_W'(450);
    endproperty
    a_pair_top: assert property (p_pair_top) else $error("pair code 15 not 450 mV");

    property p_gnd_scaled;
        @(posedge hclk) disable iff (!hresetn)
        (code_gnd == 4'hf && scale) |-> gnd_mv == MV_W'(1800);
    endproperty
    a_gnd_scaled: assert property (p_gnd_scaled) else $error("ground scale wrong");

    property p_bias_linear;
        @(posedge hclk) disable iff (!hresetn)
        (!scale && code_bias == 4'h7) |-> bias_mv == MV_W'(210);
    endproperty
    a_bias_linear: assert property (p_bias_linear) else $error("bias step wrong");
endmodule

// ---- testbench/ifd_diag_top_bench.sv ----
/* Self-checking bench of the fault diagnostic configuration block.
   Assumes the bench itself answers every measurement request. */
`timescale 1ns/100ps
`include "ifd_params.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, s); end end

module ifd_diag_top_bench;
    // ======================================================================
    // stimulus and observed signals
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        meas_valid = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [5:0]  chan_single_ended = 6'h02;
    logic [5:0]  chan_ac_coupled = 6'h04;
    logic [14:0] pos_mv = 15'h5dc;
    logic [14:0] neg_mv = 15'h5dc;
    logic [14:0] vbat_mv = 15'h1388;
    logic [14:0] bias_mv = 15'h7d0;
    wire  [31:0] hrdata;
    wire  [2:0]  meas_chan;
    wire         hreadyout, hresp, meas_req, meas_neg_on, scan_active, irq;
    logic [3:0]  log_q[$];
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;

    initial begin
        forever #5 hclk = ~hclk;
    end

    ifd_diag_top i_ifd_diag_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan_single_ended(chan_single_ended), .chan_ac_coupled(chan_ac_coupled),
        .meas_req(meas_req), .meas_chan(meas_chan), .meas_neg_on(meas_neg_on),
        .meas_valid(meas_valid), .pos_mv(pos_mv), .neg_mv(neg_mv), .vbat_mv(vbat_mv),
        .bias_mv(bias_mv), .scan_active(scan_active), .irq(irq));

    // ======================================================================
    // front end answers the cycle after each request; logs what was asked
    always @(posedge hclk) begin
        meas_valid <= meas_req;
        if (meas_req === 1'b1)
            log_q.push_back({meas_neg_on, meas_chan});
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task report_and_stop;
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ======================================================================
    // single word transfer; waits on hready, no fixed latency assumed
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= `IFD_HTRANS_NONSEQ;
        hsize <= `IFD_HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task rchk(input logic [31:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        `CHK(n, e, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask

    // three logged requests as {neg pin, channel index}
    task sel(input logic [7:0] en, input logic [11:0] e);
        log_q.delete();
        bus(1'b1, 32'h190, {24'h0, en});
        repeat (40) @(posedge hclk);
        bus(1'b1, 32'h190, 32'h0);
        repeat (10) @(posedge hclk);
        for (int i = 0; i < 3; i++) `CHK("chan order", e[11-4*i -: 4], log_q[i])
    endtask

    // repeated scans of channel 1 with given pin difference and battery level
    task thr(input logic [14:0] diff, input logic [14:0] vb, input logic [7:0] e);
        neg_mv <= 15'h5dc - diff;
        vbat_mv <= vb;
        bus(1'b1, 32'h1a0, 32'h1f);
        bus(1'b1, 32'h190, 32'h80);
        `CHK("irq clear", 1'b0, irq)
        repeat (2) @(posedge hclk);
        `CHK("scan active", 1'b1, scan_active)
        repeat (18) @(posedge hclk);
        bus(1'b1, 32'h190, 32'h0);
        repeat (10) @(posedge hclk);
        `CHK("scan idle", 1'b0, scan_active)
        rchk(32'h1a0, {24'h0, e}, "status");
        `CHK("irq", e[`IFD_EV_PAIR], irq)
        // channels 2, 3 and 6 keep their faults from the ordering scans
        rchk(32'h1a8, {24'h0, |e[3:0], 7'h64}, "live");
    endtask

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(32'h190, 32'h0, "chan enable");
        rchk(32'h194, 32'h37, "pair bat thr");
        rchk(32'h198, 32'h87, "gnd bias thr");
        sel(8'he4, 12'h81d);
        sel(8'he3, 12'h89a);
        bus(1'b1, 32'h1a4, 32'h1);
        thr(15'h59, 15'h1388, 8'h11);
        thr(15'h5a, 15'h1388, 8'h10);
        thr(15'h5a, 15'h6ad, 8'h12);
        thr(15'h5a, 15'h6ae, 8'h10);
        bus(1'b1, 32'h19c, 32'h1);
        thr(15'hb3, 15'h1388, 8'h11);
        thr(15'hb4, 15'h1388, 8'h10);
        bus(1'b1, 32'h198, 32'hffff_ff5a);
        rchk(32'h198, 32'h5a, "gnd bias rw");
        thr(15'h3b7, 15'h1388, 8'h1c);
        bus(1'b1, 32'h1ac, 32'hff);
        rchk(32'h1ac, 32'h0, "unmapped");
        report_and_stop();
    end
endmodule
